// file: pkg/silpo_pkg.sv
// Package for the serial-in latched power output block.
// Assumes a single 200 MHz system clock; pin inputs are asynchronous.
package silpo_pkg;
    // Structure
    localparam int          STAGES       = 8;
    localparam logic [7:0]  STAGE_RST    = 8'h00;
    localparam logic [7:0]  SINK_OFF_OE  = 8'hFF;
    // Input synchroniser depth (sampled taps two and three compared)
    localparam int          SYNC_DEPTH   = 3;
    // Clock period in picoseconds
    localparam int          CLK_PERIOD_PS = 5000;
    // Host spacing from last shift edge to strobe, in ns
    localparam int          SHIFT_TO_STB_NS  = 50;
    localparam int          SHIFT_TO_STB_CYC = (SHIFT_TO_STB_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    // Host least output enable pulse, in ns (4.5 us)
    localparam int          OE_PULSE_NS      = 4500;
    localparam int          OE_PULSE_CYC     = (OE_PULSE_NS * 1000 + CLK_PERIOD_PS - 1)
                                               / CLK_PERIOD_PS;
    // Buffer depth for latched words
    localparam int          BUF_DEPTH    = 2;
    // Buffer states
    typedef enum logic [2:0]
    {
        SILPO_EMPTY = 3'b001,
        SILPO_ONE   = 3'b010,
        SILPO_FULL  = 3'b100
    } silpo_buf_t;
endpackage

// file: src/silpo_top.sv
// Serial-in, latched, open-drain power output expander.
// Pins are sampled by i_ref_clk; the host keeps shift clock well below 200 MHz / 4.
`timescale 1ns/1ps
`default_nettype none

module silpo_top
    import silpo_pkg::*;
(
    // System
    input  wire logic               i_ref_clk,
    input  wire logic               i_sys_rst,
    // Host pins
    input  wire logic               i_ser_data,
    input  wire logic               i_shift_clk,
    input  wire logic               i_strobe,
    input  wire logic               i_out_en_n,
    input  wire logic               i_clear_n,
    // Latched word stream out (two-entry buffer)
    output logic                    o_word_valid,
    input  wire logic               i_word_ready,
    output logic [STAGES-1:0]       o_word_data,
    // Cascade and drivers
    output logic                    o_ser_cascade,
    output logic [STAGES-1:0]       o_sink_lines,
    output logic [STAGES-1:0]       o_sink_lines_oe_n
);

    // Three-stage synchronisers for all pins
    logic [SYNC_DEPTH-1:0] sd_q, sc_q, st_q, oe_q, cl_q;
    logic sc_f_q, st_f_q, oe_f_q, cl_f_q;
    logic [STAGES-1:0] shift_q, latch_q;

    // Debounced level: change counts once taps two and three agree
    function automatic logic filt(input logic [SYNC_DEPTH-1:0] s, input logic prev);
        filt = (s[1] == s[2]) ? s[2] : prev;
    endfunction

    // Synchroniser shift chains
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            sd_q <= '0;
            sc_q <= '0;
            st_q <= '0;
            oe_q <= '1;
            cl_q <= '1;
        end
        else
        begin
            sd_q <= {sd_q[SYNC_DEPTH-2:0], i_ser_data};
            sc_q <= {sc_q[SYNC_DEPTH-2:0], i_shift_clk};
            st_q <= {st_q[SYNC_DEPTH-2:0], i_strobe};
            oe_q <= {oe_q[SYNC_DEPTH-2:0], i_out_en_n};
            cl_q <= {cl_q[SYNC_DEPTH-2:0], i_clear_n};
        end
    end

    // Filtered pin levels
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            sc_f_q <= 1'b0;
            st_f_q <= 1'b0;
            oe_f_q <= 1'b1;
            cl_f_q <= 1'b1;
        end
        else
        begin
            sc_f_q <= filt(sc_q, sc_f_q);
            st_f_q <= filt(st_q, st_f_q);
            oe_f_q <= filt(oe_q, oe_f_q);
            cl_f_q <= filt(cl_q, cl_f_q);
        end
    end

    // Edge detection on filtered levels; clear level and unfiltered third data tap
    wire sc_rise  = ~sc_f_q & filt(sc_q, sc_f_q);
    wire st_rise  = ~st_f_q & filt(st_q, st_f_q);
    wire clr_act  = ~cl_f_q;
    wire data_bit = sd_q[2];

    // Shift stages
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            shift_q <= STAGE_RST;
        else if (clr_act)
            shift_q <= STAGE_RST;
        else if (sc_rise)
            shift_q <= {shift_q[STAGES-2:0], data_bit};
    end

    // Latch bank
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
            latch_q <= STAGE_RST;
        else if (clr_act)
            latch_q <= STAGE_RST;
        else if (st_rise)
            latch_q <= shift_q;
    end

    // Driver enable select: blank all, or invert the latch so a one sinks
    wire [STAGES-1:0] sink_oe_n_d = oe_f_q ? SINK_OFF_OE : ~latch_q;

    // Driver outputs from flops
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            o_sink_lines_oe_n <= SINK_OFF_OE;
            o_ser_cascade     <= 1'b0;
        end
        else
        begin
            o_sink_lines_oe_n <= sink_oe_n_d;
            o_ser_cascade     <= shift_q[STAGES-1];
        end
    end
    assign o_sink_lines = '0;               // Open drain only ever drives low

    // Two-entry buffer of latched words; each strobe offers the new latch word.
    // The host cannot be stalled, so a strobe into a full buffer with no pop in that cycle loses that word.
    silpo_buf_t        buf_state_q;
    logic [STAGES-1:0] b0_q, b1_q;
    // Push on every accepted strobe, pop on a completed handshake
    wire push = st_rise & ~clr_act;
    wire pop  = o_word_valid & i_word_ready;

    // Buffer occupancy and entries; entry zero is always the head word
    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            buf_state_q <= SILPO_EMPTY;
            b0_q        <= STAGE_RST;
            b1_q        <= STAGE_RST;
        end
        else
        begin
            case (buf_state_q)
                // Empty: first word goes straight to the head
                SILPO_EMPTY:
                begin
                    if (push)
                    begin
                        b0_q        <= shift_q;
                        buf_state_q <= SILPO_ONE;
                    end
                end
                // One held: a pop and push together replace the head
                SILPO_ONE:
                begin
                    if (push & pop)
                        b0_q <= shift_q;
                    else if (push)
                    begin
                        b1_q        <= shift_q;
                        buf_state_q <= SILPO_FULL;
                    end
                    else if (pop)
                        buf_state_q <= SILPO_EMPTY;
                end
                // Full: the second entry moves up on a pop
                SILPO_FULL:
                begin
                    // Newest word dropped only when both entries are held
                    if (pop)
                    begin
                        b0_q <= b1_q;
                        if (push)
                            b1_q <= shift_q;
                        else
                            buf_state_q <= SILPO_ONE;
                    end
                end
                default:
                    buf_state_q <= SILPO_EMPTY;
            endcase
        end
    end

    // Valid while any entry is held; the head stands until it is popped
    assign o_word_valid = (buf_state_q != SILPO_EMPTY);
    assign o_word_data  = b0_q;

endmodule

`default_nettype wire

// file: tb/silpo_properties.sv
// Port assertions for silpo_top.
// Bound to silpo_top; the host keeps pin levels several clocks long.
`timescale 1ns/1ps
`default_nettype none
module silpo_chk
    import silpo_pkg::*;
(
    input wire logic              i_ref_clk,
    input wire logic              i_sys_rst,
    input wire logic              i_shift_clk,
    input wire logic              i_strobe,
    input wire logic              i_out_en_n,
    input wire logic              i_clear_n,
    input wire logic              o_word_valid,
    input wire logic              i_word_ready,
    input wire logic [STAGES-1:0] o_word_data,
    input wire logic              o_ser_cascade,
    input wire logic [STAGES-1:0] o_sink_lines,
    input wire logic [STAGES-1:0] o_sink_lines_oe_n
);
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (i_sys_rst);
    // Driver pins, blanking, latch and cascade hold
    AST_SINK_LOW: assert property (o_sink_lines == 8'h00) else $error("sink not low");
    AST_OE_BLANK: assert property (i_out_en_n [*6] |-> o_sink_lines_oe_n == SINK_OFF_OE)
        else $error("drivers not blanked");
    AST_OE_FAST: assert property ($rose(i_out_en_n) |-> ##[1:6] o_sink_lines_oe_n == 8'hFF)
        else $error("blanking late");
    AST_LATCH_HOLD: assert property ((!i_out_en_n && !i_strobe && i_clear_n) [*8]
        |-> $stable(o_sink_lines_oe_n)) else $error("drivers moved without strobe");
    AST_CASC_HOLD: assert property ((!i_shift_clk && i_clear_n) [*8]
        |-> $stable(o_ser_cascade)) else $error("cascade moved without shift");
    // Clear and buffer
    AST_CLR_CASC: assert property ((!i_clear_n) [*7] |-> !o_ser_cascade)
        else $error("cascade not cleared");
    AST_CLR_OUT: assert property ((!i_clear_n) [*7] |-> o_sink_lines_oe_n == SINK_OFF_OE)
        else $error("latches not cleared");
    AST_BUF_HOLD: assert property (o_word_valid && !i_word_ready
        |=> o_word_valid && $stable(o_word_data)) else $error("buffered word lost");
endmodule
bind silpo_top silpo_chk u_chk (.*);
`default_nettype wire

// file: tb/silpo_host_model.sv
// Host controller model driving shift clock, serial data and strobe.
// Assumes a 200 MHz reference clock; pins change 1 ns after its edge.
`timescale 1ns/1ps
`default_nettype none
module silpo_host_model
    import silpo_pkg::*;
(
    input  wire logic i_ref_clk,
    output logic      o_ser_data,
    output logic      o_shift_clk,
    output logic      o_strobe
);
    // Idle pins
    initial
    begin
        o_ser_data = 1'b0;
        o_shift_clk = 1'b0;
        o_strobe = 1'b0;
    end
    task automatic wait_clk(input int n);
        repeat (n) @(posedge i_ref_clk);
        #1;
    endtask
    // shift at 12.5 MHz, first bit ends in the last stage
    task automatic send_word(input logic [7:0] w);
        for (int i = 7; i >= 0; i--)
        begin
            o_ser_data = w[i];
            wait_clk(8);
            o_shift_clk = 1'b1;
            wait_clk(8);
            o_shift_clk = 1'b0;
        end
        o_ser_data = ~w[0]; // Data released after hold
        wait_clk(SHIFT_TO_STB_CYC);
        o_strobe = 1'b1;
        wait_clk(10);
        o_strobe = 1'b0;
    endtask
endmodule
`default_nettype wire

// file: tb/test_silpo_top.sv
// Self-checking bench for silpo_top with a host model and random words.
// Assumes the 200 MHz clock and pin timing of the host model.
`timescale 1ns/1ps
`default_nettype none
module test_silpo_top;
    import silpo_pkg::*;
    logic              clk, rst, ser, sck, stb, oe_pin_n, clr_n, ready, valid, casc;
    logic [STAGES-1:0] data, sink, sink_oe_n, w;
    logic [7:0]        wq [3];
    logic [31:0]       seed = 32'h655d;
    int                fails = 0;
    int                n_checks = 0;
    silpo_top dut (.i_ref_clk(clk), .i_sys_rst(rst), .i_ser_data(ser), .i_shift_clk(sck),
        .i_strobe(stb), .i_out_en_n(oe_pin_n), .i_clear_n(clr_n), .o_word_valid(valid),
        .i_word_ready(ready), .o_word_data(data), .o_ser_cascade(casc),
        .o_sink_lines(sink), .o_sink_lines_oe_n(sink_oe_n));
    silpo_host_model host (.i_ref_clk(clk), .o_ser_data(ser), .o_shift_clk(sck), .o_strobe(stb));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    // Expected driver enables: low turns a sink on
    function automatic logic [7:0] exp_oe(input logic [7:0] l, input logic en_n);
        return en_n ? SINK_OFF_OE : ~l;
    endfunction
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e)
        begin
            fails++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_checks, fails);
        if (fails == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic pop(input logic [7:0] e);
        for (int t = 0; t < 40 && valid !== 1'b1; t++)
            step(1);
        chk("valid", 8'h01, {7'h00, valid});
        chk("word", e, data);
        ready = 1'b1;
        step(1);
        ready = 1'b0;
        step(1);
    endtask
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    initial
    begin
        rst = 1'b1;
        oe_pin_n = 1'b1;
        clr_n = 1'b1;
        ready = 1'b0;
        step(10);
        rst = 1'b0;
        oe_pin_n = 1'b0;
        // Corner and random words, each latched and popped
        for (int k = 0; k < 6; k++)
        begin
            seed = xs(seed);
            w = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : seed[7:0];
            host.send_word(w);
            step(6);
            chk("oe_n", exp_oe(w, 1'b0), sink_oe_n);
            chk("cascade", {7'h00, w[7]}, {7'h00, casc});
            chk("sink", 8'h00, sink);
            pop(w);
        end
        $display("word test done");
        // Fill the buffer while stalled, then drain it
        for (int k = 0; k < 3; k++)
        begin
            seed = xs(seed);
            wq[k] = seed[15:8];
            host.send_word(wq[k]);
        end
        step(6);
        chk("oe_n", exp_oe(wq[2], 1'b0), sink_oe_n);
        pop(wq[0]);
        pop(wq[1]);
        chk("valid", 8'h00, {7'h00, valid});
        $display("buffer test done");
        oe_pin_n = 1'b1;
        step(OE_PULSE_CYC);
        chk("oe_n", exp_oe(wq[2], 1'b1), sink_oe_n);
        oe_pin_n = 1'b0;
        step(OE_PULSE_CYC);
        chk("oe_n", exp_oe(wq[2], 1'b0), sink_oe_n);
        clr_n = 1'b0;
        step(8);
        chk("cascade", 8'h00, {7'h00, casc});
        chk("oe_n", SINK_OFF_OE, sink_oe_n);
        clr_n = 1'b1;
        $display("blank and clear test done");
        test_done();
    end
endmodule
`default_nettype wire
